// [logic/sesw_top.sv]
// Status register and write-protect logic of a serial EEPROM slave.
// Assumes an SPI master in mode 0 or 3 and a 250 MHz clk far faster than SCK.
//
// Notes on behaviour
// R01 - Falling select starts an instruction; low enables.
// R02 - Rising select ends operation or starts write.
// R03 - Select high and idle: output undriven.
// R04 - Only SPI modes 0 and 3, master clock.
// R05 - Sample input on SCK rise, shift out on fall.
// R06 - Hardware protect when pin low and enable set.
// R07 - Hold pauses, ignores clock and data, floats output.
// R08 - Master changes hold only while SCK low.
// R09 - Hold tied high means normal operation.
// R10 - Status is eight bits; locked when protected.
// R11 - Bit 0 busy flag; busy accepts status read.
// R12 - Bit 1 is latch; reset clears, command sets.
// R13 - Latch clear blocks all status and array writes.
// R14 - Bits 2-3 block guard, nonvolatile, zero delivered; the code clears them to zero on rst.
// R15 - Bits 4-6 not kept, read zero.
// R16 - Enable bit cannot drop while pin low.
// R17 - Hardware protect never guards the array.
// R18 - During internal write all status bits read one.
// R19 - Master rereads status after seeing ready.
// R20 - Master may wait 5 ms instead of polling.
// R21 - Block guard selects none, quarter, half, all.
// R22 - Guarded addresses stay read-only regardless.
// R23 - Clear latch after disable, status or array write.
// R24 - Status write keeps only guard and enable bits.
// R25 - Status write checks live protect pin level.
`timescale 1ns/1ps
module sesw_top #(
  parameter int WRITE_CYCLES = sesw_pkg::WRITE_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Serial pins from the master
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic hold_n,
  input wire logic wp_n,
  // Serial data out with its enable
  output logic so,
  output logic so_oe,
  // Launch of an array write toward the array sequencer
  output logic arr_wr_start,
  output logic [12:0] arr_wr_addr,
  output logic [7:0] arr_wr_data,
  // Status register as the master would read it
  output logic [7:0] status_view
);
  localparam int CNT_W = $clog2(WRITE_CYCLES + 1);
  localparam logic [CNT_W-1:0] WRITE_LOAD = CNT_W'(WRITE_CYCLES - 1);

  // ****************************************
  // Pin synchronisation and edges
  // ****************************************
  logic [4:0] pin_lvl;
  logic cs_lvl;
  logic sck_lvl;
  logic si_lvl;
  logic hold_lvl;
  logic wp_lvl;
  logic cs_prev_reg;
  logic sck_prev_reg;

  sesw_pin_sync #(
    .W(sesw_pkg::PIN_W),
    .RST_VAL(sesw_pkg::PIN_IDLE)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .d({wp_n, hold_n, si, sck, cs_n}),
    .q(pin_lvl)
  );

  assign cs_lvl = pin_lvl[0];
  assign sck_lvl = pin_lvl[1];
  assign si_lvl = pin_lvl[2];
  assign hold_lvl = pin_lvl[3];
  assign wp_lvl = pin_lvl[4];

  always_ff @(posedge clk) begin
    if (rst) begin
      cs_prev_reg <= 1'b1;
      sck_prev_reg <= 1'b0;
    end else begin
      cs_prev_reg <= cs_lvl;
      sck_prev_reg <= sck_lvl;
    end
  end

  logic run;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;

  // Hold tied high leaves the link running whenever select is low.
  assign run = ~cs_lvl & hold_lvl; // R01 R07 R09
  // Only the clock's own edges matter, so mode 0 and mode 3 behave alike.
  assign sck_rise = run & sck_lvl & ~sck_prev_reg; // R04 R05
  assign sck_fall = run & ~sck_lvl & sck_prev_reg; // R05
  assign cs_fall = ~cs_lvl & cs_prev_reg; // R01
  assign cs_rise = cs_lvl & ~cs_prev_reg; // R02

  // ****************************************
  // Protection state and guard
  // ****************************************
  logic wen_reg;
  logic [1:0] bp_reg;
  logic gen_reg;
  logic busy_reg;
  logic [CNT_W-1:0] wcnt_reg;
  logic pend_status_reg;
  logic [1:0] pend_bp_reg;
  logic pend_gen_reg;
  logic [7:0] stat_now;
  logic [7:0] data_reg;
  logic [15:0] addr_reg;

  sesw_guard_if g ();

  assign g.bp = bp_reg;
  assign g.gen = gen_reg;
  assign g.wen = wen_reg;
  assign g.wp_n = wp_lvl;
  assign g.new_gen = data_reg[sesw_pkg::BIT_GEN];
  assign g.addr = addr_reg[12:0];

  sesw_guard u_guard (
    .g(g.guard)
  );

  always_comb begin
    if (busy_reg) begin
      stat_now = sesw_pkg::STAT_BUSY_VIEW; // R18
    end else begin
      stat_now = '0; // R15
      stat_now[sesw_pkg::BIT_RDY] = 1'b0; // R11
      stat_now[sesw_pkg::BIT_WEN] = wen_reg; // R12
      stat_now[sesw_pkg::BIT_BP_HI:sesw_pkg::BIT_BP_LO] = bp_reg; // R14
      stat_now[sesw_pkg::BIT_GEN] = gen_reg;
    end
  end

  // ****************************************
  // Instruction decode
  // ****************************************
  function automatic sesw_pkg::sesw_cmd_e decode_op(input logic [7:0] op, input logic busy);
    sesw_pkg::sesw_cmd_e c;
    logic [6:0] k;
    k = {op[7:4], op[2:0]};
    case (k)
      sesw_pkg::OP_LATCH_SET: c = sesw_pkg::SESW_CMD_LATCH_SET;
      sesw_pkg::OP_LATCH_CLEAR: c = sesw_pkg::SESW_CMD_LATCH_CLEAR;
      sesw_pkg::OP_STATUS_READ: c = sesw_pkg::SESW_CMD_STATUS_READ;
      sesw_pkg::OP_STATUS_WRITE: c = sesw_pkg::SESW_CMD_STATUS_WRITE;
      sesw_pkg::OP_ARRAY_WRITE: c = sesw_pkg::SESW_CMD_ARRAY_WRITE;
      default: c = sesw_pkg::SESW_CMD_NONE;
    endcase
    // While a write runs, only the status read gets through.
    if (busy && c != sesw_pkg::SESW_CMD_STATUS_READ) begin
      c = sesw_pkg::SESW_CMD_NONE; // R11
    end
    return c;
  endfunction

  // ****************************************
  // Serial receive
  // ****************************************
  sesw_pkg::sesw_phase_e phase_reg;
  sesw_pkg::sesw_cmd_e cmd_reg;
  sesw_pkg::sesw_cmd_e cmd_next;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic got_byte_reg;
  logic op_end;

  assign shift_next = {shift_reg[6:0], si_lvl};
  assign cmd_next = decode_op(shift_next, busy_reg);
  assign op_end = sck_rise & (phase_reg == sesw_pkg::SESW_OP) & (bit_cnt_reg == sesw_pkg::OP_LAST);

  always_ff @(posedge clk) begin
    if (rst) begin
      phase_reg <= sesw_pkg::SESW_OP;
      cmd_reg <= sesw_pkg::SESW_CMD_NONE;
      bit_cnt_reg <= '0;
      shift_reg <= '0;
      got_byte_reg <= 1'b0;
      data_reg <= '0;
      addr_reg <= '0;
    end else if (cs_fall) begin
      // Every instruction starts afresh at the select edge.
      phase_reg <= sesw_pkg::SESW_OP; // R01
      cmd_reg <= sesw_pkg::SESW_CMD_NONE;
      bit_cnt_reg <= '0;
      got_byte_reg <= 1'b0;
    end else if (sck_rise) begin
      case (phase_reg)
        sesw_pkg::SESW_OP: begin
          shift_reg <= shift_next; // R05
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
          if (bit_cnt_reg == sesw_pkg::OP_LAST) begin
            bit_cnt_reg <= '0;
            cmd_reg <= cmd_next;
            case (cmd_next)
              sesw_pkg::SESW_CMD_STATUS_READ: phase_reg <= sesw_pkg::SESW_RDOUT;
              sesw_pkg::SESW_CMD_STATUS_WRITE: phase_reg <= sesw_pkg::SESW_DATA;
              sesw_pkg::SESW_CMD_ARRAY_WRITE: phase_reg <= sesw_pkg::SESW_ADDR;
              default: phase_reg <= sesw_pkg::SESW_SKIP;
            endcase
          end
        end
        sesw_pkg::SESW_ADDR: begin
          addr_reg <= {addr_reg[14:0], si_lvl};
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
          if (bit_cnt_reg == sesw_pkg::ADDR_LAST) begin
            bit_cnt_reg <= '0;
            phase_reg <= sesw_pkg::SESW_DATA;
          end
        end
        sesw_pkg::SESW_DATA: begin
          shift_reg <= shift_next;
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
          if (bit_cnt_reg == sesw_pkg::DATA_LAST) begin
            bit_cnt_reg <= '0;
            got_byte_reg <= 1'b1;
            data_reg <= shift_next;
            // A status write carries one byte; anything after it is ignored.
            if (cmd_reg == sesw_pkg::SESW_CMD_STATUS_WRITE) begin
              phase_reg <= sesw_pkg::SESW_SKIP;
            end
          end
        end
        default: begin
          phase_reg <= phase_reg;
        end
      endcase
    end
  end

  // ****************************************
  // Write latch, status bits and self-timed write
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      wen_reg <= sesw_pkg::WEN_RESET; // R12
      bp_reg <= sesw_pkg::BP_RESET; // R14
      gen_reg <= sesw_pkg::GEN_RESET;
      busy_reg <= 1'b0;
      wcnt_reg <= '0;
      pend_status_reg <= 1'b0;
      pend_bp_reg <= sesw_pkg::BP_RESET;
      pend_gen_reg <= sesw_pkg::GEN_RESET;
      arr_wr_start <= 1'b0;
      arr_wr_addr <= '0;
      arr_wr_data <= '0;
    end else begin
      arr_wr_start <= 1'b0;
      if (busy_reg) begin
        if (wcnt_reg == '0) begin
          busy_reg <= 1'b0;
          wen_reg <= 1'b0; // R23
          // Stored bits change only as the write cycle ends.
          if (pend_status_reg) begin
            bp_reg <= pend_bp_reg; // R24
            gen_reg <= pend_gen_reg; // R24
          end
          pend_status_reg <= 1'b0;
        end else begin
          wcnt_reg <= wcnt_reg - 1'b1;
        end
      end else if (cs_rise) begin
        case (cmd_reg) // R02
          sesw_pkg::SESW_CMD_LATCH_SET: begin
            wen_reg <= 1'b1; // R12
          end
          sesw_pkg::SESW_CMD_LATCH_CLEAR: begin
            wen_reg <= 1'b0; // R23
          end
          sesw_pkg::SESW_CMD_STATUS_WRITE: begin
            if (got_byte_reg && g.status_ok) begin // R10 R13 R16 R25
              busy_reg <= 1'b1;
              wcnt_reg <= WRITE_LOAD;
              pend_status_reg <= 1'b1;
              pend_bp_reg <= data_reg[sesw_pkg::BIT_BP_HI:sesw_pkg::BIT_BP_LO]; // R24
              pend_gen_reg <= data_reg[sesw_pkg::BIT_GEN]; // R24
            end
          end
          sesw_pkg::SESW_CMD_ARRAY_WRITE: begin
            if (got_byte_reg && g.array_ok) begin // R13 R17 R22
              busy_reg <= 1'b1;
              wcnt_reg <= WRITE_LOAD;
              arr_wr_start <= 1'b1;
              arr_wr_addr <= addr_reg[12:0];
              arr_wr_data <= data_reg;
            end
          end
          default: begin
            busy_reg <= 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      status_view <= '0;
    end else begin
      status_view <= stat_now;
    end
  end

  // ****************************************
  // Serial data out
  // ****************************************
  logic [7:0] out_sh_reg;
  logic [2:0] out_cnt_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      so <= 1'b0;
      so_oe <= 1'b0;
      out_sh_reg <= '0;
      out_cnt_reg <= '0;
    end else begin
      // Undriven when deselected, held, or not in a read.
      so_oe <= run & (phase_reg == sesw_pkg::SESW_RDOUT); // R03 R07
      if (op_end && cmd_next == sesw_pkg::SESW_CMD_STATUS_READ) begin
        out_sh_reg <= stat_now;
        out_cnt_reg <= '0;
      end else if (sck_fall && phase_reg == sesw_pkg::SESW_RDOUT) begin
        so <= out_sh_reg[7]; // R05
        out_cnt_reg <= out_cnt_reg + 3'h1;
        // Each new byte takes a fresh snapshot, so polling sees ready appear.
        if (out_cnt_reg == sesw_pkg::OUT_LAST) begin
          out_sh_reg <= stat_now; // R11 R18
        end else begin
          out_sh_reg <= {out_sh_reg[6:0], 1'b0};
        end
      end
    end
  end
endmodule

// [logic/sesw_pkg.sv]
// Shared constants and types for the serial EEPROM status and write-protect block.
// Assumes a single 250 MHz clock and pin levels sampled by the block's own synchroniser.
package sesw_pkg;

  // ****************************************
  // Status register layout
  // ****************************************
  localparam int STAT_W = 8;
  localparam int BIT_RDY = 0;
  localparam int BIT_WEN = 1;
  localparam int BIT_BP_LO = 2;
  localparam int BIT_BP_HI = 3;
  localparam int BIT_GEN = 7;
  localparam logic [7:0] STAT_BUSY_VIEW = 8'hFF;
  localparam logic [1:0] BP_RESET = 2'h0;
  localparam logic GEN_RESET = 1'h0;
  localparam logic WEN_RESET = 1'h0;

  // ****************************************
  // Instruction codes, upper nibble and low three bits
  // ****************************************
  localparam logic [6:0] OP_LATCH_SET = 7'h06;
  localparam logic [6:0] OP_LATCH_CLEAR = 7'h04;
  localparam logic [6:0] OP_STATUS_READ = 7'h05;
  localparam logic [6:0] OP_STATUS_WRITE = 7'h01;
  localparam logic [6:0] OP_ARRAY_WRITE = 7'h02;

  // ****************************************
  // Serial framing, last bit index of each field
  // ****************************************
  localparam logic [3:0] OP_LAST = 4'h7;
  localparam logic [3:0] ADDR_LAST = 4'hF;
  localparam logic [3:0] DATA_LAST = 4'h7;
  localparam logic [2:0] OUT_LAST = 3'h7;

  // ****************************************
  // Array protection ranges
  // ****************************************
  localparam int ADDR_W = 13;
  localparam logic [1:0] BP_NONE = 2'h0;
  localparam logic [1:0] BP_QUARTER = 2'h1;
  localparam logic [1:0] BP_HALF = 2'h2;
  localparam logic [12:0] QUARTER_BASE = 13'h1800;
  localparam logic [12:0] HALF_BASE = 13'h1000;

  // ****************************************
  // Pin synchroniser, order {wp_n, hold_n, si, sck, cs_n}
  // ****************************************
  localparam int PIN_W = 5;
  localparam logic [4:0] PIN_IDLE = 5'h19;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int WRITE_TIME_MS = 4;
  localparam int WRITE_CYCLES = WRITE_TIME_MS * 1000000 / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    SESW_OP, SESW_ADDR, SESW_DATA, SESW_RDOUT, SESW_SKIP
  } sesw_phase_e;

  typedef enum logic [2:0] {
    SESW_CMD_NONE, SESW_CMD_LATCH_SET, SESW_CMD_LATCH_CLEAR,
    SESW_CMD_STATUS_READ, SESW_CMD_STATUS_WRITE, SESW_CMD_ARRAY_WRITE
  } sesw_cmd_e;

endpackage

// [logic/sesw_guard_if.sv]
// Carries protection state to the guard logic and its decisions back.
// Assumes the control side drives every input member from registers or synced pins.
`timescale 1ns/1ps
interface sesw_guard_if;
  logic [1:0] bp;
  logic gen;
  logic wen;
  logic wp_n;
  logic new_gen;
  logic [12:0] addr;
  logic hw_on;
  logic addr_locked;
  logic status_ok;
  logic array_ok;
  modport ctrl (
    output bp, gen, wen, wp_n, new_gen, addr,
    input hw_on, addr_locked, status_ok, array_ok
  );
  modport guard (
    input bp, gen, wen, wp_n, new_gen, addr,
    output hw_on, addr_locked, status_ok, array_ok
  );
endinterface

// [logic/sesw_pin_sync.sv]
// Three-stage synchroniser with agreement filter for asynchronous pins.
// Assumes the pins are stable for several clock cycles between changes.
`timescale 1ns/1ps
module sesw_pin_sync #(
  parameter int W = 5,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pins and filtered levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk) begin
      if (rst) begin
        s1_reg[i] <= RST_VAL[i];
        s2_reg[i] <= RST_VAL[i];
        s3_reg[i] <= RST_VAL[i];
        q[i] <= RST_VAL[i];
      end else begin
        s1_reg[i] <= d[i];
        s2_reg[i] <= s1_reg[i];
        s3_reg[i] <= s2_reg[i];
        // A change counts only once the last two stages agree.
        if (s2_reg[i] == s3_reg[i]) begin
          q[i] <= s3_reg[i];
        end
      end
    end
  end
endmodule

// [logic/sesw_guard.sv]
// Write-protection decisions for status register and array writes.
// Assumes the protect pin level given is the live synchronised one.
`timescale 1ns/1ps
module sesw_guard (
  // Protection state in, decisions out
  sesw_guard_if.guard g
);
  // Hardware protection needs the pin low and the enable bit set.
  assign g.hw_on = ~g.wp_n & g.gen; // R06

  always_comb begin
    case (g.bp) // R21
      sesw_pkg::BP_NONE: g.addr_locked = 1'b0;
      sesw_pkg::BP_QUARTER: g.addr_locked = (g.addr >= sesw_pkg::QUARTER_BASE);
      sesw_pkg::BP_HALF: g.addr_locked = (g.addr >= sesw_pkg::HALF_BASE);
      default: g.addr_locked = 1'b1;
    endcase
  end

  // The enable bit may not drop while the pin is low, checked on the live level.
  assign g.status_ok = g.wen & ~g.hw_on & ~(g.gen & ~g.new_gen & ~g.wp_n); // R10 R13 R16 R25

  // The pin never guards the array; only the latch and the block range do.
  assign g.array_ok = g.wen & ~g.addr_locked; // R13 R17 R22
endmodule

// [verification/sesw_chk.sv]
// Concurrent checks on the ports of the status and write-protect block.
// Assumes it is bound to sesw_top and sees only that module's ports.
`timescale 1ns/1ps
module sesw_chk #(
  parameter int WRITE_CYCLES = 50
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Serial pins
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic hold_n,
  input wire logic wp_n,
  input wire logic so,
  input wire logic so_oe,
  // Array launch and status
  input wire logic arr_wr_start,
  input wire logic [12:0] arr_wr_addr,
  input wire logic [7:0] arr_wr_data,
  input wire logic [7:0] status_view
);
  // ****************************************
  // Helper counters
  // ****************************************
  int cs_hi_cnt;
  int busy_cnt;
  always_ff @(posedge clk) begin
    if (rst || !cs_n) cs_hi_cnt <= 0;
    else if (cs_hi_cnt < 15) cs_hi_cnt <= cs_hi_cnt + 1;
  end
  always_ff @(posedge clk) begin
    if (rst || !status_view[0]) busy_cnt <= 0;
    else busy_cnt <= busy_cnt + 1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ****************************************
  // Assertions
  // ****************************************
  a_reset_clear: assert property ($fell(rst) |-> status_view == 8'h00 && !so_oe)
    else $error("status not cleared by reset");
  a_idle_float: assert property (cs_hi_cnt >= 10 |-> !so_oe)
    else $error("output driven while deselected");
  a_hold_float: assert property (!hold_n [*8] |-> !so_oe)
    else $error("output driven during hold");
  a_busy_view: assert property (status_view[0] |-> status_view == 8'hFF)
    else $error("busy status not all ones");
  a_spare_zero: assert property (!status_view[0] |-> status_view[6:4] == 3'h0)
    else $error("spare status bits kept");
  a_busy_len: assert property ($fell(status_view[0]) |->
    busy_cnt >= WRITE_CYCLES && busy_cnt <= WRITE_CYCLES + 2)
    else $error("write cycle length wrong");
  a_latch_drop: assert property ($fell(status_view[0]) |-> !status_view[1])
    else $error("latch kept after write cycle");
  a_start_busy: assert property (arr_wr_start |-> ##[0:4] status_view == 8'hFF)
    else $error("array write without busy");
  a_busy_nostart: assert property ($past(status_view[0], 8) && status_view[0] |->
    !arr_wr_start)
    else $error("array write accepted while busy");
  a_select_start: assert property (!cs_n [*8] |-> !arr_wr_start)
    else $error("array write launched while selected");
endmodule

// [verification/sesw_master_model.sv]
// Serial master model driving select, clock, data, hold and protect pins.
// Assumes the bench clock paces every pin change; mode 0 or 3, 160 ns serial clock.
`timescale 1ns/1ps
module sesw_master_model (
  // Bench clock
  input wire logic clk,
  // Pins toward the device
  output logic cs_n,
  output logic sck,
  output logic si,
  output logic hold_n,
  output logic wp_n,
  // Data back from the device
  input wire logic so,
  input wire logic so_oe
);
  // Idle level of the serial clock: 0 gives mode 0, 1 gives mode 3.
  logic cpol;
  initial begin
    cpol = 1'b0;
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    hold_n = 1'b1;
    wp_n = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // An undriven output is read as unknown so a floating pin never passes a compare.
  task automatic xfer(input logic [31:0] bits, input int n, input int hold_at,
    output logic [7:0] rd);
    rd = 8'h00;
    sck = cpol;
    tick(10);
    cs_n = 1'b0;
    tick(10);
    for (int i = n - 1; i >= 0; i--) begin
      sck = 1'b0;
      if (i == hold_at) begin
        // Hold moves only once the clock has settled low, so only the extra pulse driven during hold is masked.
        tick(10);
        hold_n = 1'b0;
        tick(10);
        sck = 1'b1;
        tick(10);
        sck = 1'b0;
        tick(10);
        hold_n = 1'b1;
        tick(10);
      end
      si = bits[i];
      tick(20);
      sck = 1'b1;
      rd = {rd[6:0], so_oe ? so : 1'bx};
      tick(20);
    end
    sck = cpol;
    tick(20);
    cs_n = 1'b1;
    si = ~si;
    tick(20);
  endtask
endmodule

// [verification/testbench.sv]
// Self-checking bench for the status and write-protect block.
// Assumes the master model paces all pin changes just after clk rises.
`timescale 1ns/1ps
module testbench;
  localparam int WCYC = 2000;
  logic clk, rst, cs_n, sck, si, hold_n, wp_n, so, so_oe, arr_wr_start;
  logic [12:0] arr_wr_addr, last_addr;
  logic [12:0] ok_a [1:3];
  logic [12:0] bad_a [1:3];
  logic [7:0] arr_wr_data, status_view, rd, exp_st, last_data;
  int failures = 0;
  int comparisons = 0;
  int starts = 0;
  int n_start = 0;
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin failures++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    if (arr_wr_start === 1'b1) begin
      starts++;
      last_addr <= arr_wr_addr;
      last_data <= arr_wr_data;
    end
  end
  sesw_top #(.WRITE_CYCLES(WCYC)) sesw_top_inst (.clk(clk), .rst(rst), .cs_n(cs_n),
    .sck(sck), .si(si), .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe(so_oe),
    .arr_wr_start(arr_wr_start), .arr_wr_addr(arr_wr_addr), .arr_wr_data(arr_wr_data),
    .status_view(status_view));
  sesw_master_model sesw_master_model_inst (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si),
    .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe(so_oe));
  function automatic logic [7:0] opb(input logic [6:0] o);
    return {o[6:3], 1'b0, o[2:0]};
  endfunction
  task automatic op(input logic [31:0] b, input int n);
    sesw_master_model_inst.xfer(b, n, -1, rd);
  endtask
  task automatic status_read_cmd(input logic [7:0] exp, input int hold_at);
    sesw_master_model_inst.xfer(32'({opb(sesw_pkg::OP_STATUS_READ), 8'h00}), 16, hold_at, rd);
    `CHK(rd, exp)
  endtask
  task automatic wait_ready;
    int k;
    k = 0;
    while (status_view[0] !== 1'b0 && k < 4 * WCYC) begin
      sesw_master_model_inst.tick(1);
      k++;
    end
    if (k >= 4 * WCYC) begin
      failures++;
      test_done();
    end
  endtask
  task automatic test_done;
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    ok_a = '{13'h17FF, 13'h0FFF, 13'h0000};
    bad_a = '{13'h1800, 13'h1000, 13'h0000};
    sesw_master_model_inst.tick(5);
    rst = 1'b0;
    sesw_master_model_inst.tick(10);
    `CHK(status_view, 8'h00)
    `CHK(so_oe, 1'b0)
    status_read_cmd(8'h00, -1);
    op(32'({opb(sesw_pkg::OP_STATUS_WRITE), 8'h8C}), 16);
    status_read_cmd(8'h00, -1);
    op(32'(opb(sesw_pkg::OP_LATCH_SET)), 8);
    `CHK(status_view, 8'h02)
    op(32'(opb(sesw_pkg::OP_LATCH_CLEAR)), 8);
    `CHK(status_view, 8'h00)
    $display("test reset and latch done");
    op(32'(opb(sesw_pkg::OP_LATCH_SET)), 8);
    op(32'({opb(sesw_pkg::OP_STATUS_WRITE), 8'hFC}), 16);
    `CHK(status_view, 8'hFF)
    status_read_cmd(8'hFF, -1);
    op(32'(opb(sesw_pkg::OP_LATCH_SET)), 8);
    wait_ready();
    status_read_cmd(8'h8C, -1);
    status_read_cmd(8'h8C, -1);
    $display("test status write done");
    sesw_master_model_inst.wp_n = 1'b0;
    op(32'(opb(sesw_pkg::OP_LATCH_SET)), 8);
    op(32'({opb(sesw_pkg::OP_STATUS_WRITE), 8'h0C}), 16);
    `CHK(status_view, 8'h8E)
    $display("test hardware protect done");
    for (int b = 1; b <= 3; b++) begin
      exp_st = {1'b1, 3'h0, 2'(b), 2'h0};
      sesw_master_model_inst.wp_n = 1'b1;
      op(32'(opb(sesw_pkg::OP_LATCH_SET)), 8);
      op(32'({opb(sesw_pkg::OP_STATUS_WRITE), exp_st}), 16);
      sesw_master_model_inst.tick(WCYC + 20);
      status_read_cmd(exp_st, -1);
      sesw_master_model_inst.wp_n = 1'b0;
      op(32'(opb(sesw_pkg::OP_LATCH_SET)), 8);
      op({opb(sesw_pkg::OP_ARRAY_WRITE), 3'b101, bad_a[b], 8'h5A}, 32);
      `CHK(starts, n_start)
      if (b < 3) begin
        op({opb(sesw_pkg::OP_ARRAY_WRITE), 3'b101, ok_a[b], 8'hA5}, 32);
        wait_ready();
        n_start++;
        `CHK(starts, n_start)
        `CHK(last_addr, ok_a[b])
        `CHK(last_data, 8'hA5)
        `CHK(status_view, exp_st)
      end
    end
    $display("test block ranges done");
    sesw_master_model_inst.cpol = 1'b1;
    status_read_cmd(8'h8E, -1);
    $display("test mode 3 done");
    status_read_cmd(8'h8E, 3);
    $display("test hold done");
    rst = 1'b1;
    sesw_master_model_inst.tick(5);
    rst = 1'b0;
    sesw_master_model_inst.tick(10);
    `CHK(status_view, 8'h00)
    $display("test second reset done");
    test_done();
  end
endmodule
bind sesw_top sesw_chk #(.WRITE_CYCLES(WRITE_CYCLES)) sesw_chk_inst (.clk(clk), .rst(rst),
  .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe(so_oe),
  .arr_wr_start(arr_wr_start), .arr_wr_addr(arr_wr_addr), .arr_wr_data(arr_wr_data),
  .status_view(status_view));
